// ==== logic/hpw_pkg.sv ====
package hpw_pkg;
  // ==========================================================
  // register offsets
  localparam logic [2:0] ADDR_PWR = 3'h0;
  localparam logic [2:0] ADDR_CLK = 3'h1;
  localparam logic [2:0] ADDR_WDT = 3'h2;
  localparam logic [2:0] ADDR_PAWM = 3'h3;
  localparam logic [2:0] ADDR_STAT = 3'h4;
  // ==========================================================
  // field positions
  localparam int PWR_DEEP_BIT = 0;
  localparam int PWR_LATCH_BIT = 1;
  localparam int PWR_TB0_BIT = 4;
  localparam int PWR_PA_BIT = 7;
  localparam int CLK_SLOW_BIT = 0;
  localparam int CLK_FAST_BIT = 1;
  localparam int WDT_EN_BIT = 3;
  // ==========================================================
  // values after reset, watchdog counter width
  localparam logic [7:0] PWR_RST = 8'h00;
  localparam logic [1:0] CLK_RST = 2'h0;
  localparam logic WDT_EN_RST = 1'b1;
  localparam logic [2:0] WDT_SEL_RST = 3'h3;
  localparam int WDT_CNT_W = 19;
  // ==========================================================
  // types
  typedef enum logic [2:0] {
    PM_RUN, PM_IDLE_SLOW, PM_IDLE_BOTH, PM_IDLE_FAST, PM_SLEEP, PM_DEEP
  } hpw_mode_t;
  typedef enum logic [1:0] {ST_RUN, ST_LOW, ST_STAB} hpw_state_t;
  typedef enum logic [1:0] {WK_NONE, WK_PORTA, WK_IRQ, WK_WDT} hpw_wake_t;

  // power-of-two exponent of the watchdog division ratio
  function automatic logic [4:0] wdt_exp(input logic [2:0] sel);
    case (sel)
      3'h0: wdt_exp = 5'h08;
      3'h1: wdt_exp = 5'h0a;
      3'h2: wdt_exp = 5'h0c;
      3'h3: wdt_exp = 5'h0e;
      3'h4: wdt_exp = 5'h0f;
      3'h5: wdt_exp = 5'h10;
      3'h6: wdt_exp = 5'h11;
      default: wdt_exp = 5'h12;
    endcase
  endfunction : wdt_exp
endpackage : hpw_pkg

// ==== logic/hpw_ctrl.sv ====
`timescale 1ns/10ps
// What this block does
// - idle slow-only: fast clock off, slow on
// - idle both: both clocks run, core stops
// - idle fast-only: fast on, slow off unless watchdog enabled
// - deep select wins: deep sleep, watchdog only
// - entry sets powered-down, clears timeout flag
// - entry clears watchdog; enable decides counting
// - idle modes hold memory, registers, pins
// - deep sleep holds pins only if latched
// - sleep/idle wake: port A, interrupt, watchdog
// - deep wake only port A or timebase0
// - powered-down flag cleared by reset, clear-watchdog
// - watchdog wake sets timeout, resets PC/SP
// - per-pin port A wake enable, falling edge
// - port A wake: next instruction, deep: zero
// - disabled or stack full: resume, stay pending
// - enabled with free stack: take interrupt
// - timebase0 deep wake restarts at zero
// - interrupts pending at entry never wake
// - wait for stopped oscillator to stabilise
// - watchdog counts slow ticks, 3-bit ratio
// - both keep bits clear: sleep, watchdog only
// - deep sleep turns regulator off by hardware
module hpw_ctrl #(
  parameter int NUM_IRQ = 8,
  parameter int TB0_IDX = 0,
  parameter int PA_W = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [2:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic halt_in,
  input wire logic clear_watchdog_instruction_in,
  input wire logic stack_full_in,
  input wire logic [NUM_IRQ-1:0] irq_req_in,
  input wire logic [NUM_IRQ-1:0] irq_en_in,
  input wire logic [PA_W-1:0] port_a_in,
  input wire logic slow_tick_in,
  input wire logic fast_osc_stable_in,
  output logic fast_clk_en_out,
  output logic slow_clk_en_out,
  output logic cpu_run_out,
  output logic ldo_on_out,
  output logic io_hold_out,
  output logic wdt_run_out,
  output logic powered_down_flag_out,
  output logic watchdog_timeout_flag_out,
  output logic [2:0] mode_out,
  output logic resume_next_out,
  output logic restart_zero_out,
  output logic irq_entry_out,
  output logic pc_sp_reset_out,
  output logic wdt_reset_out
);

  // ==========================================================
  // parameter check
  if (NUM_IRQ < 1 || TB0_IDX < 0 || TB0_IDX >= NUM_IRQ || PA_W < 1 || PA_W > 8) begin : g_bad_param
    $error("hpw_ctrl: bad interrupt count, timebase index or port A width");
  end

  // ==========================================================
  // state
  hpw_pkg::hpw_state_t state_q;
  hpw_pkg::hpw_mode_t mode_q, sel_mode;
  hpw_pkg::hpw_wake_t wake_q, wake_src;
  logic [7:0] pwr_q;
  logic [2:0] wdt_sel_q;
  logic [PA_W-1:0] pawm_q, pa_prev_q, pa_fall;
  logic [NUM_IRQ-1:0] pre_irq_q, irq_wake_q, irq_new, irq_wake;
  logic [hpw_pkg::WDT_CNT_W-1:0] wdt_cnt_q, wdt_lim;
  logic fast_keep_q, slow_keep_q, wdt_en_q, pdf_q, tmo_q;
  logic wdt_ovf, halt_take, is_low, is_deep, fast_stopped, stab_done;

  assign halt_take = (state_q == hpw_pkg::ST_RUN) && halt_in;
  assign is_low = (state_q == hpw_pkg::ST_LOW);
  assign is_deep = (mode_q == hpw_pkg::PM_DEEP);

  // ==========================================================
  // mode decode
  always_comb begin
    if (pwr_q[hpw_pkg::PWR_DEEP_BIT]) begin
      sel_mode = hpw_pkg::PM_DEEP;
    end else begin
      case ({fast_keep_q, slow_keep_q})
        2'b01: sel_mode = hpw_pkg::PM_IDLE_SLOW;
        2'b11: sel_mode = hpw_pkg::PM_IDLE_BOTH;
        2'b10: sel_mode = hpw_pkg::PM_IDLE_FAST;
        default: sel_mode = hpw_pkg::PM_SLEEP;
      endcase
    end
  end

  // fast oscillator is off in these modes and must restart on wake
  assign fast_stopped = (mode_q == hpw_pkg::PM_IDLE_SLOW) || (mode_q == hpw_pkg::PM_SLEEP) || is_deep;

  // ==========================================================
  // clock, regulator and retention controls
  assign fast_clk_en_out = !(is_low && fast_stopped);
  // watchdog enable keeps the slow oscillator alive regardless of mode
  assign slow_clk_en_out = wdt_en_q || !(is_low && (mode_q == hpw_pkg::PM_IDLE_FAST ||
                           mode_q == hpw_pkg::PM_SLEEP || is_deep));
  assign cpu_run_out = (state_q == hpw_pkg::ST_RUN);
  assign ldo_on_out = !(is_low && is_deep);
  // pin latch stays on after a deep wake until software clears it
  assign io_hold_out = pwr_q[hpw_pkg::PWR_LATCH_BIT] ||
                       ((state_q != hpw_pkg::ST_RUN) && !is_deep);
  assign wdt_run_out = wdt_en_q;
  assign powered_down_flag_out = pdf_q;
  assign watchdog_timeout_flag_out = tmo_q;
  assign mode_out = 3'(mode_q);

  // ==========================================================
  // wake sources
  assign pa_fall = pa_prev_q & ~port_a_in & pawm_q;
  assign irq_new = irq_req_in & ~pre_irq_q;
  always_comb begin
    irq_wake = irq_new;
    if (is_deep) begin
      irq_wake = '0;
      irq_wake[TB0_IDX] = irq_new[TB0_IDX];
    end
  end
  always_comb begin
    wake_src = hpw_pkg::WK_NONE;
    if (|pa_fall) begin
      wake_src = hpw_pkg::WK_PORTA;
    end else if (|irq_wake) begin
      wake_src = hpw_pkg::WK_IRQ;
    end else if (wdt_ovf && !is_deep) begin
      wake_src = hpw_pkg::WK_WDT;
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pa_prev_q <= '1;
    end else begin
      pa_prev_q <= port_a_in;
    end
  end

  // ==========================================================
  // sequencer
  assign stab_done = !fast_stopped || fast_osc_stable_in;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= hpw_pkg::ST_RUN;
      mode_q <= hpw_pkg::PM_RUN;
      wake_q <= hpw_pkg::WK_NONE;
      pre_irq_q <= '0;
      irq_wake_q <= '0;
    end else begin
      case (state_q)
        hpw_pkg::ST_RUN: begin
          if (halt_in) begin
            state_q <= hpw_pkg::ST_LOW;
            mode_q <= sel_mode;
            pre_irq_q <= irq_req_in;
          end
        end
        hpw_pkg::ST_LOW: begin
          if (wake_src != hpw_pkg::WK_NONE) begin
            state_q <= hpw_pkg::ST_STAB;
            wake_q <= wake_src;
            irq_wake_q <= irq_wake;
          end
        end
        hpw_pkg::ST_STAB: begin
          if (stab_done) begin
            state_q <= hpw_pkg::ST_RUN;
            mode_q <= hpw_pkg::PM_RUN;
            wake_q <= hpw_pkg::WK_NONE;
          end
        end
        default: begin
          state_q <= hpw_pkg::ST_RUN;
          mode_q <= hpw_pkg::PM_RUN;
        end
      endcase
    end
  end

  // ==========================================================
  // resume actions, one-cycle pulses as normal operation returns
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      resume_next_out <= 1'b0;
      restart_zero_out <= 1'b0;
      irq_entry_out <= 1'b0;
      pc_sp_reset_out <= 1'b0;
    end else begin
      resume_next_out <= 1'b0;
      restart_zero_out <= 1'b0;
      irq_entry_out <= 1'b0;
      pc_sp_reset_out <= 1'b0;
      if (state_q == hpw_pkg::ST_STAB && stab_done) begin
        case (wake_q)
          hpw_pkg::WK_PORTA: begin
            restart_zero_out <= is_deep;
            resume_next_out <= !is_deep;
          end
          hpw_pkg::WK_IRQ: begin
            if (is_deep) begin
              restart_zero_out <= 1'b1;
            end else if ((|(irq_wake_q & irq_en_in)) && !stack_full_in) begin
              irq_entry_out <= 1'b1;
            end else begin
              resume_next_out <= 1'b1;
            end
          end
          hpw_pkg::WK_WDT: pc_sp_reset_out <= 1'b1;
          default: resume_next_out <= 1'b0;
        endcase
      end
    end
  end

  // ==========================================================
  // watchdog counter on slow oscillator ticks
  assign wdt_lim = (19'h00001 << hpw_pkg::wdt_exp(wdt_sel_q)) - 19'h00001;
  assign wdt_ovf = wdt_en_q && slow_tick_in && (wdt_cnt_q == wdt_lim);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wdt_cnt_q <= '0;
    end else if (halt_take || clear_watchdog_instruction_in || wdt_ovf) begin
      wdt_cnt_q <= '0;
    end else if (wdt_en_q && slow_tick_in) begin
      wdt_cnt_q <= wdt_cnt_q + 19'h00001;
    end
  end

  // overflow while running is a full device reset request
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wdt_reset_out <= 1'b0;
    end else begin
      wdt_reset_out <= wdt_ovf && (state_q == hpw_pkg::ST_RUN);
    end
  end

  // ==========================================================
  // status flags, set wins over clear
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pdf_q <= 1'b0;
    end else if (halt_take) begin
      pdf_q <= 1'b1;
    end else if (clear_watchdog_instruction_in) begin
      pdf_q <= 1'b0;
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tmo_q <= 1'b0;
    end else if (wdt_ovf) begin
      tmo_q <= 1'b1;
    end else if (halt_take) begin
      tmo_q <= 1'b0;
    end
  end

  // ==========================================================
  // register port
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pwr_q <= hpw_pkg::PWR_RST;
    end else begin
      if (reg_wr_in && reg_addr_in == hpw_pkg::ADDR_PWR) begin
        pwr_q[hpw_pkg::PWR_DEEP_BIT] <= reg_wdata_in[hpw_pkg::PWR_DEEP_BIT];
        pwr_q[hpw_pkg::PWR_LATCH_BIT] <= reg_wdata_in[hpw_pkg::PWR_LATCH_BIT];
        pwr_q[hpw_pkg::PWR_PA_BIT] <= reg_wdata_in[hpw_pkg::PWR_PA_BIT];
        pwr_q[hpw_pkg::PWR_TB0_BIT] <= reg_wdata_in[hpw_pkg::PWR_TB0_BIT];
      end
      if (is_low && is_deep && wake_src == hpw_pkg::WK_PORTA) begin
        pwr_q[hpw_pkg::PWR_PA_BIT] <= 1'b1;
      end
      if (is_low && is_deep && wake_src == hpw_pkg::WK_IRQ) begin
        pwr_q[hpw_pkg::PWR_TB0_BIT] <= 1'b1;
      end
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fast_keep_q <= hpw_pkg::CLK_RST[hpw_pkg::CLK_FAST_BIT];
      slow_keep_q <= hpw_pkg::CLK_RST[hpw_pkg::CLK_SLOW_BIT];
    end else if (reg_wr_in && reg_addr_in == hpw_pkg::ADDR_CLK) begin
      fast_keep_q <= reg_wdata_in[hpw_pkg::CLK_FAST_BIT];
      slow_keep_q <= reg_wdata_in[hpw_pkg::CLK_SLOW_BIT];
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wdt_en_q <= hpw_pkg::WDT_EN_RST;
      wdt_sel_q <= hpw_pkg::WDT_SEL_RST;
    end else if (reg_wr_in && reg_addr_in == hpw_pkg::ADDR_WDT) begin
      wdt_en_q <= reg_wdata_in[hpw_pkg::WDT_EN_BIT];
      wdt_sel_q <= reg_wdata_in[2:0];
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pawm_q <= '0;
    end else if (reg_wr_in && reg_addr_in == hpw_pkg::ADDR_PAWM) begin
      pawm_q <= reg_wdata_in[PA_W-1:0];
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in || !reg_rd_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      case (reg_addr_in)
        hpw_pkg::ADDR_PWR: reg_rdata_out <= pwr_q & 8'h93;
        hpw_pkg::ADDR_CLK: reg_rdata_out <= {6'h00, fast_keep_q, slow_keep_q};
        hpw_pkg::ADDR_WDT: reg_rdata_out <= {4'h0, wdt_en_q, wdt_sel_q};
        hpw_pkg::ADDR_PAWM: reg_rdata_out <= 8'(pawm_q);
        hpw_pkg::ADDR_STAT: reg_rdata_out <= {3'h0, 3'(mode_q), tmo_q, pdf_q};
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // checks
  mode_held_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (is_low && $past(is_low)) |-> $stable(mode_q))
    else $error("mode changed while halted");
  idle_slow_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (is_low && mode_q == hpw_pkg::PM_IDLE_SLOW) |->
    (!fast_clk_en_out && slow_clk_en_out && !cpu_run_out))
    else $error("idle slow-only clocks wrong");
  idle_both_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (is_low && mode_q == hpw_pkg::PM_IDLE_BOTH) |->
    (fast_clk_en_out && slow_clk_en_out && !cpu_run_out))
    else $error("idle both clocks wrong");
  idle_fast_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (is_low && mode_q == hpw_pkg::PM_IDLE_FAST) |->
    (fast_clk_en_out && slow_clk_en_out == wdt_en_q))
    else $error("idle fast-only clocks wrong");
  deep_off_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (halt_take && pwr_q[hpw_pkg::PWR_DEEP_BIT]) |=>
    (!fast_clk_en_out && !ldo_on_out && is_deep))
    else $error("deep sleep entry wrong");
  entry_flags_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (halt_take && !wdt_ovf) |=> (pdf_q && !tmo_q && wdt_cnt_q == '0))
    else $error("entry flags or watchdog not cleared");
  pdf_clear_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (clear_watchdog_instruction_in && !halt_take) |=> !pdf_q)
    else $error("powered-down flag not cleared");
  deep_stay_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (is_low && is_deep && !(|pa_fall) && !irq_new[TB0_IDX]) |=> is_low)
    else $error("deep sleep ended by wrong source");
  stab_wait_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == hpw_pkg::ST_STAB && fast_stopped && !fast_osc_stable_in) |=>
    !cpu_run_out)
    else $error("resumed before oscillator stable");
  wdt_wake_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (is_low && !is_deep && wdt_ovf && !(|pa_fall) && !(|irq_wake) &&
     !fast_stopped) |=> ##1 (pc_sp_reset_out && tmo_q && cpu_run_out))
    else $error("watchdog wake action wrong");
endmodule : hpw_ctrl

// ==== tb/hpw_core_model.sv ====
`timescale 1ns/10ps
// ==========================================================
// core and oscillator stand-in facing the power controller
module hpw_core_model #(
  parameter int NUM_IRQ = 8,
  parameter int STAB_CYC = 6,
  parameter int TICK_DIV = 4
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic halt_cmd_in,
  input wire logic [NUM_IRQ-1:0] irq_set_in,
  input wire logic [NUM_IRQ-1:0] irq_en_in,
  input wire logic irq_entry_in,
  input wire logic fast_clk_en_in,
  input wire logic slow_clk_en_in,
  output logic halt_out,
  output logic [NUM_IRQ-1:0] irq_req_out,
  output logic fast_osc_stable_out,
  output logic slow_tick_out
);
  logic [7:0] stab_q;
  logic [7:0] div_q;
  logic [NUM_IRQ-1:0] serve;
  // lowest enabled request is the one the core services
  assign serve = irq_entry_in ? ((irq_req_out & irq_en_in) & (~(irq_req_out & irq_en_in) + NUM_IRQ'(1))) : '0;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      halt_out <= 1'b0;
      irq_req_out <= '0;
    end else begin
      halt_out <= halt_cmd_in;
      irq_req_out <= (irq_req_out | irq_set_in) & ~serve;
    end
  end
  // ==========================================================
  // oscillator restarts from zero whenever its gate closes
  always_ff @(posedge clk_in) begin
    if (rst_in || !fast_clk_en_in) begin
      stab_q <= 8'h00;
    end else if (stab_q != 8'(STAB_CYC)) begin
      stab_q <= stab_q + 8'h01;
    end
  end
  assign fast_osc_stable_out = (stab_q == 8'(STAB_CYC));
  // slow ticks stand still while the slow gate is closed
  always_ff @(posedge clk_in) begin
    if (rst_in || !slow_clk_en_in) begin
      div_q <= 8'h00;
      slow_tick_out <= 1'b0;
    end else begin
      slow_tick_out <= (div_q == 8'(TICK_DIV - 1));
      div_q <= (div_q == 8'(TICK_DIV - 1)) ? 8'h00 : div_q + 8'h01;
    end
  end
endmodule : hpw_core_model

// ==== tb/tb_hpw_ctrl.sv ====
`timescale 1ns/10ps
module tb_hpw_ctrl;
  localparam int STAB = 6;
  localparam int TDIV = 4;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic clear_watchdog_instruction = 1'b0;
  logic stack_full = 1'b0;
  logic halt_cmd = 1'b0;
  logic [7:0] irq_en = 8'hff;
  logic [7:0] irq_set = 8'h00;
  logic [7:0] port_a = 8'hff;
  logic [7:0] rdata, irq_req, rd_v;
  logic halt, osc_ok, tick, fast_en, slow_en, cpu_run, ldo_on, io_hold, wdt_run, powered_down_flag, tmo;
  logic [2:0] mode;
  logic resume_next, restart_zero, irq_entry, pc_sp_reset, wdt_rst;
  int n_fail = 0;
  int checks = 0;
  int cycles = 0;
  int n;
  always #2 clk_in = ~clk_in;
  hpw_ctrl #(.NUM_IRQ(8), .TB0_IDX(0), .PA_W(8)) hpw_ctrl_i (
    .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata), .halt_in(halt),
    .clear_watchdog_instruction_in(clear_watchdog_instruction), .stack_full_in(stack_full), .irq_req_in(irq_req), .irq_en_in(irq_en),
    .port_a_in(port_a), .slow_tick_in(tick), .fast_osc_stable_in(osc_ok), .fast_clk_en_out(fast_en),
    .slow_clk_en_out(slow_en), .cpu_run_out(cpu_run), .ldo_on_out(ldo_on), .io_hold_out(io_hold),
    .wdt_run_out(wdt_run), .powered_down_flag_out(powered_down_flag), .watchdog_timeout_flag_out(tmo),
    .mode_out(mode), .resume_next_out(resume_next), .restart_zero_out(restart_zero),
    .irq_entry_out(irq_entry), .pc_sp_reset_out(pc_sp_reset), .wdt_reset_out(wdt_rst));
  hpw_core_model #(.NUM_IRQ(8), .STAB_CYC(STAB), .TICK_DIV(TDIV)) hpw_core_model_i (
    .clk_in(clk_in), .rst_in(rst_in), .halt_cmd_in(halt_cmd), .irq_set_in(irq_set), .irq_en_in(irq_en),
    .irq_entry_in(irq_entry), .fast_clk_en_in(fast_en), .slow_clk_en_in(slow_en), .halt_out(halt),
    .irq_req_out(irq_req), .fast_osc_stable_out(osc_ok), .slow_tick_out(tick));
  // ==========================================================
  // shared helpers
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_in);
    reg_wr <= 1'b0;
    // let the write land before a caller looks at outputs
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] a);
    @(posedge clk_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_in);
    reg_rd <= 1'b0;
    #1;
    rd_v = rdata;
  endtask : rd_reg
  task automatic do_halt();
    @(posedge clk_in);
    halt_cmd <= 1'b1;
    @(posedge clk_in);
    halt_cmd <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    chk("program stopped", cpu_run, 1'b0);
  endtask : do_halt
  task automatic irq_pulse(input logic [7:0] v);
    @(posedge clk_in);
    irq_set <= v;
    @(posedge clk_in);
    irq_set <= 8'h00;
  endtask : irq_pulse
  // pulses stand in the cycle where the core runs again
  task automatic wait_run();
    n = 0;
    while (cpu_run !== 1'b1 && n < 3000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    chk("woke within bound", n < 3000, 1'b1);
  endtask : wait_run
  // ==========================================================
  // scenarios
  task automatic test_reset();
    logic [7:0] ev [6] = '{hpw_pkg::PWR_RST, {6'h00, hpw_pkg::CLK_RST},
      {4'h0, hpw_pkg::WDT_EN_RST, hpw_pkg::WDT_SEL_RST}, 8'h00, 8'h00, 8'h00};
    chk("outputs after reset", {cpu_run, fast_en, ldo_on, io_hold, wdt_run}, 8'h1d);
    for (int a = 0; a < 6; a++) begin
      rd_reg(3'(a));
      chk("reset value", rd_v, ev[a]);
    end
    wr_reg(hpw_pkg::ADDR_STAT, 8'hff);
    wr_reg(3'h6, 8'hff);
    rd_reg(hpw_pkg::ADDR_STAT);
    chk("status read only", rd_v, 8'h00);
    rd_reg(3'h6);
    chk("unmapped reads zero", rd_v, 8'h00);
    $display("test reset done");
  endtask : test_reset
  task automatic test_wdt();
    wr_reg(hpw_pkg::ADDR_WDT, 8'h08);
    // idle with both clocks, so the wake needs no oscillator wait
    wr_reg(hpw_pkg::ADDR_CLK, 8'h03);
    chk("watchdog running", wdt_run, 1'b1);
    repeat (600) @(posedge clk_in);
    do_halt();
    wait_run();
    chk("watchdog wake reset", pc_sp_reset, 1'b1);
    chk("count restarted at halt", n >= 255 * TDIV && n <= 260 * TDIV, 1'b1);
    rd_reg(hpw_pkg::ADDR_STAT);
    chk("flags after watchdog wake", rd_v & 8'h03, 8'h03);
    @(posedge clk_in);
    clear_watchdog_instruction <= 1'b1;
    @(posedge clk_in);
    clear_watchdog_instruction <= 1'b0;
    rd_reg(hpw_pkg::ADDR_STAT);
    chk("powered-down cleared", rd_v & 8'h03, 8'h02);
    $display("test watchdog done");
  endtask : test_wdt
  task automatic test_modes();
    logic [7:0] pv [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h03};
    logic [7:0] cv [5] = '{8'h01, 8'h03, 8'h02, 8'h00, 8'h03};
    logic [2:0] mv [5] = '{hpw_pkg::PM_IDLE_SLOW, hpw_pkg::PM_IDLE_BOTH, hpw_pkg::PM_IDLE_FAST,
      hpw_pkg::PM_SLEEP, hpw_pkg::PM_DEEP};
    logic [3:0] ov [5] = '{4'b0111, 4'b1111, 4'b1011, 4'b0011, 4'b0001};
    wr_reg(hpw_pkg::ADDR_WDT, 8'h00);
    chk("watchdog stopped", wdt_run, 1'b0);
    wr_reg(hpw_pkg::ADDR_PAWM, 8'h40);
    for (int i = 0; i < 5; i++) begin
      wr_reg(hpw_pkg::ADDR_PWR, pv[i]);
      wr_reg(hpw_pkg::ADDR_CLK, cv[i]);
      do_halt();
      wr_reg(hpw_pkg::ADDR_CLK, ~cv[i]);
      #1;
      chk("mode held", mode, mv[i]);
      chk("gates", {fast_en, slow_en, ldo_on, io_hold}, ov[i]);
      rd_reg(hpw_pkg::ADDR_STAT);
      chk("status on entry", rd_v, {3'h0, mv[i], 2'b01});
      @(posedge clk_in);
      port_a[1] <= 1'b0;
      repeat (8) @(posedge clk_in);
      port_a[6] <= 1'b0;
      #1;
      chk("unmasked pin ignored", cpu_run, 1'b0);
      wait_run();
      chk("resume after halt", resume_next, i != 4);
      chk("restart at zero", restart_zero, i == 4);
      if (!ov[i][3]) chk("oscillator settled", n >= STAB, 1'b1);
      @(posedge clk_in);
      port_a <= 8'hff;
    end
    rd_reg(hpw_pkg::ADDR_PWR);
    chk("port a deep wake flag", rd_v, 8'h83);
    wr_reg(hpw_pkg::ADDR_PWR, 8'h00);
    $display("test modes done");
  endtask : test_modes
  task automatic test_irq();
    wr_reg(hpw_pkg::ADDR_CLK, 8'h03);
    irq_pulse(8'h08);
    do_halt();
    repeat (20) @(posedge clk_in);
    #1;
    chk("pending request never wakes", cpu_run, 1'b0);
    irq_pulse(8'h04);
    wait_run();
    chk("interrupt entry", irq_entry, 1'b1);
    chk("no plain resume", resume_next, 1'b0);
    @(posedge clk_in);
    stack_full <= 1'b1;
    do_halt();
    irq_pulse(8'h20);
    wait_run();
    chk("resume when stack full", resume_next, 1'b1);
    chk("entry withheld", irq_entry, 1'b0);
    chk("request still pending", irq_req[5], 1'b1);
    @(posedge clk_in);
    stack_full <= 1'b0;
    irq_en <= 8'h7f;
    do_halt();
    irq_pulse(8'h80);
    wait_run();
    chk("resume when disabled", resume_next, 1'b1);
    chk("disabled not entered", irq_entry, 1'b0);
    @(posedge clk_in);
    irq_en <= 8'hff;
    $display("test interrupts done");
  endtask : test_irq
  task automatic test_deep();
    wr_reg(hpw_pkg::ADDR_WDT, 8'h08);
    // settings kept in memory beforehand by software
    wr_reg(hpw_pkg::ADDR_PWR, 8'h01);
    do_halt();
    irq_pulse(8'h40);
    repeat (1100) @(posedge clk_in);
    #1;
    chk("deep ignores other sources", cpu_run, 1'b0);
    rd_reg(hpw_pkg::ADDR_STAT);
    chk("timeout set in deep", rd_v & 8'h03, 8'h03);
    irq_pulse(8'h01);
    wait_run();
    chk("timebase restart", restart_zero, 1'b1);
    rd_reg(hpw_pkg::ADDR_PWR);
    chk("timebase deep wake flag", rd_v, 8'h11);
    wr_reg(hpw_pkg::ADDR_PWR, 8'h00);
    // watchdog left running: its next overflow hits while the core runs
    n = 0;
    while (wdt_rst !== 1'b1 && n < 1100) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    chk("overflow while running resets", wdt_rst, 1'b1);
    $display("test deep sleep done");
  endtask : test_deep
  // ==========================================================
  // run control
  task automatic conclude();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // ceiling well above the roughly 4000 cycles the tests need
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    test_reset();
    test_wdt();
    test_modes();
    test_irq();
    test_deep();
    conclude();
  end
endmodule : tb_hpw_ctrl
